// *** design/dsau_pkg.sv ***
// constants and types shared by the data space access unit
package dsau_pkg;

  // address and data widths
  localparam int EA_W     = 16;
  localparam int DATA_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int NEAR_W   = 13;
  localparam int WREG_N   = 16;
  localparam int WSEL_W   = 4;
  localparam int EA_TOP   = 15;

  // data space map
  localparam logic [EA_W-1:0] SFR_LAST  = 16'h07ff;
  localparam logic [EA_W-1:0] RAM_BASE  = 16'h0800;
  localparam int              RAM_BYTES = 30720;

  // pointer steps
  localparam logic [EA_W-1:0] BYTE_STEP = 16'h0001;
  localparam logic [EA_W-1:0] WORD_STEP = 16'h0002;

  // reset values
  localparam logic [DATA_W-1:0] WREG_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {AM_INDIRECT, AM_POSTINC, AM_NEAR, AM_ABS} dsau_amode_t;
  typedef enum logic [1:0] {EXT_NONE, EXT_SIGN, EXT_ZERO} dsau_ext_t;
  typedef enum logic [1:0] {RG_SFR, RG_RAM, RG_NONE, RG_PSV} dsau_region_t;

endpackage : dsau_pkg

// *** design/dsau_agu_if.sv ***
// address generation signals between the access unit and one generator
`timescale 1ns/1ns
interface dsau_agu_if;
  import dsau_pkg::*;

  dsau_amode_t       mode;
  logic [EA_W-1:0]   ptr;
  logic [EA_W-1:0]   literal;
  logic              isByte;
  logic [EA_W-1:0]   ea;
  logic [EA_W-1:0]   nextPtr;
  logic              misaligned;

  modport agu  (input mode, ptr, literal, isByte, output ea, nextPtr, misaligned);
  modport core (output mode, ptr, literal, isByte, input ea, nextPtr, misaligned);
endinterface : dsau_agu_if

// *** design/dsau_agu.sv ***
// one address generation unit: effective address, post-increment, alignment
`timescale 1ns/1ns
module dsau_agu
  import dsau_pkg::*;
(
  dsau_agu_if.agu port
);

  wire [EA_W-1:0] step;
  wire [EA_W-1:0] nearEa;

  // near field reaches the lowest 8 Kbytes
  assign nearEa = {{(EA_W-NEAR_W){1'b0}}, port.literal[NEAR_W-1:0]};

  assign port.ea = (port.mode == AM_NEAR) ? nearEa :
                   (port.mode == AM_ABS)  ? port.literal :
                   port.ptr;

  // byte ops step by one, word ops by two
  assign step         = port.isByte ? BYTE_STEP : WORD_STEP;
  assign port.nextPtr = port.ptr + step;

  // word access at odd byte address
  assign port.misaligned = !port.isByte && port.ea[0];

endmodule : dsau_agu

// *** design/dsau_access_unit.sv ***
// data space access unit: decode, byte lanes, ram, working registers, trap
`timescale 1ns/1ns
module dsau_access_unit
  import dsau_pkg::*;
#(
  parameter int RAM_SIZE = RAM_BYTES
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // read address generator request
  input  wire logic                rdReq,
  input  wire dsau_amode_t         rdMode,
  input  wire logic [WSEL_W-1:0]   rdPtrSel,
  input  wire logic [EA_W-1:0]     rdLiteral,
  input  wire logic                rdIsByte,
  // read result
  output logic                     rdValid,
  output logic [DATA_W-1:0]        rdData,
  // write address generator request
  input  wire logic                wrReq,
  input  wire dsau_amode_t         wrMode,
  input  wire logic [WSEL_W-1:0]   wrPtrSel,
  input  wire logic [EA_W-1:0]     wrLiteral,
  input  wire logic                wrIsByte,
  input  wire logic [DATA_W-1:0]   wrData,
  // exception request
  output logic                     addrErrTrap,
  // working register port
  input  wire logic                wregWrEn,
  input  wire logic [WSEL_W-1:0]   wregWrSel,
  input  wire logic                wregWrByte,
  input  wire logic [DATA_W-1:0]   wregWrData,
  input  wire dsau_ext_t           extOp,
  input  wire logic [WSEL_W-1:0]   extSel,
  input  wire logic [WSEL_W-1:0]   wregRdSel,
  output logic [DATA_W-1:0]        wregRdData,
  // special function register bus
  output logic                     sfrRdEn,
  output logic [EA_W-1:0]          sfrRdAddr,
  input  wire logic [DATA_W-1:0]   sfrRdData,
  input  wire logic                sfrRdHit,
  output logic [1:0]               sfrWrEn,
  output logic [EA_W-1:0]          sfrWrAddr,
  output logic [DATA_W-1:0]        sfrWrData,
  // program space window
  output logic                     psvRdEn,
  output logic [EA_W-1:0]          psvRdAddr,
  input  wire logic [DATA_W-1:0]   psvRdData
);

  localparam int RAM_WORDS = RAM_SIZE / 2;
  localparam int IDX_W     = $clog2(RAM_WORDS);
  localparam logic [EA_W:0] RAM_END = 17'(RAM_BASE) + 17'(RAM_SIZE);

  // region of an effective address
  function automatic dsau_region_t regionOf(input logic [EA_W-1:0] ea);
    dsau_region_t r;
    r = RG_NONE;
    if (ea[EA_TOP])
      r = RG_PSV;
    else if (ea <= SFR_LAST)
      r = RG_SFR;
    else if ({1'b0, ea} < RAM_END)
      r = RG_RAM;
    return r;
  endfunction : regionOf

  // working registers and data memory
  logic [DATA_W-1:0] wreg [WREG_N];
  logic [DATA_W-1:0] next_wreg [WREG_N];
  logic [DATA_W-1:0] ram [RAM_WORDS];

  // independent read and write generators
  dsau_agu_if rdAgu ();
  dsau_agu_if wrAgu ();

  dsau_agu u_rd_agu (
    .port (rdAgu.agu)
  );

  dsau_agu u_wr_agu (
    .port (wrAgu.agu)
  );

  assign rdAgu.mode    = rdMode;
  assign rdAgu.ptr     = wreg[rdPtrSel];
  assign rdAgu.literal = rdLiteral;
  assign rdAgu.isByte  = rdIsByte;
  assign wrAgu.mode    = wrMode;
  assign wrAgu.ptr     = wreg[wrPtrSel];
  assign wrAgu.literal = wrLiteral;
  assign wrAgu.isByte  = wrIsByte;

  // read decode
  wire dsau_region_t    rdRegion;
  wire [EA_W-1:0]       rdOff;
  wire [IDX_W-1:0]      rdIdx;
  wire [EA_W-1:0]       rdWordEa;
  wire                  ramRd;
  wire                  sfrRd;
  wire                  psvRd;

  assign rdRegion = regionOf(rdAgu.ea);
  assign rdOff    = rdAgu.ea - RAM_BASE;
  assign rdIdx    = rdOff[IDX_W:1];
  assign rdWordEa = {rdAgu.ea[EA_W-1:1], 1'b0};
  assign ramRd    = rdReq && (rdRegion == RG_RAM);
  assign sfrRd    = rdReq && (rdRegion == RG_SFR);
  assign psvRd    = rdReq && (rdRegion == RG_PSV);

  // write decode
  wire dsau_region_t    wrRegion;
  wire [EA_W-1:0]       wrOff;
  wire [IDX_W-1:0]      wrIdx;
  wire                  wrAllowed;
  wire [1:0]            wrLanes;
  wire [DATA_W-1:0]     wrLaneData;
  wire                  ramWr;
  wire                  sfrWr;

  assign wrRegion   = regionOf(wrAgu.ea);
  assign wrOff      = wrAgu.ea - RAM_BASE;
  assign wrIdx      = wrOff[IDX_W:1];
  assign wrAllowed  = wrReq && !wrAgu.misaligned;
  assign wrLanes    = wrIsByte ? (wrAgu.ea[0] ? 2'h2 : 2'h1) : 2'h3;
  assign wrLaneData = wrIsByte ? {wrData[BYTE_W-1:0], wrData[BYTE_W-1:0]} : wrData;
  assign ramWr      = wrAllowed && (wrRegion == RG_RAM);
  assign sfrWr      = wrAllowed && (wrRegion == RG_SFR);

  // ram byte lanes written independently
  always_ff @(posedge clk)
  begin
    if (ramWr && wrLanes[0])
      ram[wrIdx][BYTE_W-1:0] <= wrLaneData[BYTE_W-1:0];
    if (ramWr && wrLanes[1])
      ram[wrIdx][DATA_W-1:BYTE_W] <= wrLaneData[DATA_W-1:BYTE_W];
  end

  // first read stage: word fetch and external bus strobes
  logic                s1Valid;
  dsau_region_t        s1Region;
  logic                s1Odd;
  logic                s1Byte;
  logic                s1Mis;
  logic [DATA_W-1:0]   s1RamWord;

  always_ff @(posedge clk)
  begin
    if (ramRd)
      s1RamWord <= ram[rdIdx];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1Valid   <= 1'b0;
      s1Region  <= RG_NONE;
      s1Odd     <= 1'b0;
      s1Byte    <= 1'b0;
      s1Mis     <= 1'b0;
      sfrRdEn   <= 1'b0;
      sfrRdAddr <= ZERO_WORD;
      psvRdEn   <= 1'b0;
      psvRdAddr <= ZERO_WORD;
    end
    else
    begin
      s1Valid   <= rdReq;
      s1Region  <= rdRegion;
      s1Odd     <= rdAgu.ea[0];
      s1Byte    <= rdIsByte;
      s1Mis     <= rdAgu.misaligned;
      sfrRdEn   <= sfrRd;
      sfrRdAddr <= rdWordEa;
      psvRdEn   <= psvRd;
      psvRdAddr <= rdWordEa;
    end
  end

  // second read stage: region select and byte steering
  logic [DATA_W-1:0] s1Word;
  wire  [BYTE_W-1:0] s1Pick;
  wire  [DATA_W-1:0] s1Result;

  always_comb
  begin
    unique case (s1Region)
      RG_SFR:  s1Word = sfrRdHit ? sfrRdData : ZERO_WORD;
      RG_RAM:  s1Word = s1RamWord;
      RG_PSV:  s1Word = psvRdData;
      RG_NONE: s1Word = ZERO_WORD;
    endcase
  end

  assign s1Pick   = s1Odd ? s1Word[DATA_W-1:BYTE_W] : s1Word[BYTE_W-1:0];
  assign s1Result = s1Byte ? {ZERO_BYTE, s1Pick} : s1Word;

  // trap: read after completion, write after suppression
  wire rdTrap;
  wire wrTrap;

  assign rdTrap = s1Valid && s1Mis;
  assign wrTrap = wrReq && wrAgu.misaligned;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdValid     <= 1'b0;
      rdData      <= ZERO_WORD;
      addrErrTrap <= 1'b0;
    end
    else
    begin
      rdValid     <= s1Valid;
      rdData      <= s1Valid ? s1Result : ZERO_WORD;
      addrErrTrap <= rdTrap || wrTrap;
    end
  end

  // special register write strobes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfrWrEn   <= 2'h0;
      sfrWrAddr <= ZERO_WORD;
      sfrWrData <= ZERO_WORD;
    end
    else
    begin
      sfrWrEn   <= sfrWr ? wrLanes : 2'h0;
      sfrWrAddr <= {wrAgu.ea[EA_W-1:1], 1'b0};
      sfrWrData <= wrLaneData;
    end
  end

  // working register update, explicit write has highest priority
  wire [DATA_W-1:0] extSrc;
  wire [DATA_W-1:0] extSigned;
  wire [DATA_W-1:0] extUnsigned;
  wire [DATA_W-1:0] byteLoad;

  assign extSrc      = wreg[extSel];
  assign extSigned   = {{BYTE_W{extSrc[BYTE_W-1]}}, extSrc[BYTE_W-1:0]};
  assign extUnsigned = {ZERO_BYTE, extSrc[BYTE_W-1:0]};
  assign byteLoad    = {wreg[wregWrSel][DATA_W-1:BYTE_W], wregWrData[BYTE_W-1:0]};

  always_comb
  begin
    next_wreg = wreg;
    if (rdReq && rdMode == AM_POSTINC)
      next_wreg[rdPtrSel] = rdAgu.nextPtr;
    if (wrReq && wrMode == AM_POSTINC)
      next_wreg[wrPtrSel] = wrAgu.nextPtr;
    if (extOp == EXT_SIGN)
      next_wreg[extSel] = extSigned;
    else if (extOp == EXT_ZERO)
      next_wreg[extSel] = extUnsigned;
    if (wregWrEn)
      next_wreg[wregWrSel] = wregWrByte ? byteLoad : wregWrData;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wreg       <= '{default: WREG_RST};
      wregRdData <= ZERO_WORD;
    end
    else
    begin
      wreg       <= next_wreg;
      wregRdData <= wreg[wregRdSel];
    end
  end

endmodule : dsau_access_unit

// *** testbench/dsau_access_unit_properties.sv ***
// port checker of the data space access unit
`timescale 1ns/1ns
module dsau_access_unit_properties
  import dsau_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // read side
  input wire logic        rdReq,
  input wire dsau_amode_t rdMode,
  input wire logic [15:0] rdLiteral,
  input wire logic        rdIsByte,
  input wire logic        rdValid,
  input wire logic [15:0] rdData,
  // write side
  input wire logic        wrReq,
  input wire dsau_amode_t wrMode,
  input wire logic [15:0] wrLiteral,
  input wire logic        wrIsByte,
  // trap and far side
  input wire logic        addrErrTrap,
  input wire logic        sfrRdEn,
  input wire logic [15:0] sfrRdAddr,
  input wire logic [1:0]  sfrWrEn,
  input wire logic        psvRdEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rdAbs = rdReq && rdMode == AM_ABS;
  wire wrAbs = wrReq && wrMode == AM_ABS;
  wire wrOdd = wrAbs && !wrIsByte && wrLiteral[0];
  wire wrLane = wrLiteral[0];

  rd_latency_a: assert property (rdReq |-> ##2 rdValid)
    else $error("read answer late");
  rd_trap_a: assert property (rdAbs && !rdIsByte && rdLiteral[0] |-> ##2 addrErrTrap)
    else $error("odd word read without trap");
  wr_trap_a: assert property (wrOdd |=> addrErrTrap)
    else $error("odd word write without trap");
  trap_cause_a: assert property (addrErrTrap |-> $past(rdReq, 2) || $past(wrReq))
    else $error("trap without access");
  wr_suppress_a: assert property (wrOdd |=> sfrWrEn == 2'h0)
    else $error("odd word write not suppressed");
  window_route_a: assert property (rdAbs && rdLiteral[15] |=> psvRdEn && !sfrRdEn)
    else $error("window read misrouted");
  sfr_route_a: assert property (rdAbs && rdLiteral <= 16'h07ff |=>
    sfrRdEn && sfrRdAddr == ($past(rdLiteral) & 16'hfffe))
    else $error("register read misrouted");
  byte_lane_a: assert property (wrAbs && wrIsByte && wrLiteral <= 16'h07ff |=>
    sfrWrEn[1] == $past(wrLane) && sfrWrEn[0] != sfrWrEn[1])
    else $error("wrong byte lane");
  byte_high_a: assert property (rdValid && $past(rdIsByte, 2) |-> rdData[15:8] == 8'h00)
    else $error("byte read high lane not zero");
  near_ram_a: assert property (rdReq && rdMode == AM_NEAR |=> !psvRdEn)
    else $error("near read reached window");
  cover property (rdValid && addrErrTrap);
  cover property (psvRdEn);
  cover property (sfrWrEn == 2'h2);
endmodule : dsau_access_unit_properties

bind dsau_access_unit dsau_access_unit_properties u_props (.clk, .nrst, .rdReq, .rdMode,
  .rdLiteral, .rdIsByte, .rdValid, .rdData, .wrReq, .wrMode, .wrLiteral, .wrIsByte,
  .addrErrTrap, .sfrRdEn, .sfrRdAddr, .sfrWrEn, .psvRdEn);

// *** testbench/dsau_far_side_model.sv ***
// far side model: register file and program window
`timescale 1ns/1ns
module dsau_far_side_model
(
  // register read bus
  input  wire logic        sfrRdEn,
  input  wire logic [15:0] sfrRdAddr,
  output logic [15:0]      sfrRdData,
  output logic             sfrRdHit,
  // window read bus
  input  wire logic        psvRdEn,
  input  wire logic [15:0] psvRdAddr,
  output logic [15:0]      psvRdData
);
  wire [15:0] sfrVal = sfrRdAddr + 16'h1234;
  wire [15:0] psvVal = {psvRdAddr[7:0], ~psvRdAddr[7:0]};
  // only the lowest 256 bytes hold registers
  assign sfrRdHit = sfrRdEn && sfrRdAddr < 16'h0100;
  // idle buses show the inverse so stale data never matches
  assign sfrRdData = sfrRdEn ? sfrVal : ~sfrVal;
  assign psvRdData = psvRdEn ? psvVal : ~psvVal;
endmodule : dsau_far_side_model

// *** testbench/tb_data_space_access_unit.sv ***
// self-checking bench of the data space access unit
`timescale 1ns/1ns
module tb_data_space_access_unit
  import dsau_pkg::*;
;
  logic        clk, nrst, rdReq, rdIsByte, wrReq, wrIsByte;
  logic        wregWrEn, wregWrByte, rdValid, addrErrTrap;
  logic        sfrRdEn, sfrRdHit, psvRdEn;
  logic [1:0]  sfrWrEn;
  logic [3:0]  rdPtrSel, wrPtrSel, wregWrSel, extSel, wregRdSel;
  logic [15:0] rdLiteral, wrLiteral, wrData, wregWrData, rdData, wregRdData;
  logic [15:0] sfrRdAddr, sfrRdData, sfrWrAddr, sfrWrData, psvRdAddr, psvRdData;
  dsau_amode_t rdMode, wrMode;
  dsau_ext_t   extOp;
  int          fails, checksDone;

  dsau_access_unit #(.RAM_SIZE(32'h4000)) uut (.clk, .nrst, .rdReq, .rdMode, .rdPtrSel,
    .rdLiteral, .rdIsByte, .rdValid, .rdData, .wrReq, .wrMode, .wrPtrSel, .wrLiteral,
    .wrIsByte, .wrData, .addrErrTrap, .wregWrEn, .wregWrSel, .wregWrByte, .wregWrData,
    .extOp, .extSel, .wregRdSel, .wregRdData, .sfrRdEn, .sfrRdAddr, .sfrRdData, .sfrRdHit,
    .sfrWrEn, .sfrWrAddr, .sfrWrData, .psvRdEn, .psvRdAddr, .psvRdData);
  dsau_far_side_model far (.sfrRdEn, .sfrRdAddr, .sfrRdData, .sfrRdHit, .psvRdEn,
    .psvRdAddr, .psvRdData);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input dsau_amode_t m, input logic [3:0] s, input logic [15:0] a,
                    input logic b, input logic [15:0] exp);
    rdMode = m;
    rdPtrSel = s;
    rdLiteral = a;
    rdIsByte = b;
    rdReq = 1'b1;
    @(posedge clk);
    #1 rdReq = 1'b0;
    @(posedge clk);
    #1 chk({15'h0000, rdValid}, 16'h0001);
    chk(rdData, exp);
  endtask : rd

  task automatic wr(input dsau_amode_t m, input logic [15:0] a, input logic b,
                    input logic [15:0] d);
    wrMode = m;
    wrLiteral = a;
    wrIsByte = b;
    wrData = d;
    wrReq = 1'b1;
    @(posedge clk);
    #1 wrReq = 1'b0;
  endtask : wr

  task automatic wrw(input logic [3:0] s, input logic b, input logic [15:0] d);
    wregWrSel = s;
    wregWrByte = b;
    wregWrData = d;
    wregWrEn = 1'b1;
    @(posedge clk);
    #1 wregWrEn = 1'b0;
  endtask : wrw

  task automatic ext(input dsau_ext_t op, input logic [3:0] s);
    extOp = op;
    extSel = s;
    @(posedge clk);
    #1 extOp = EXT_NONE;
  endtask : ext

  task automatic idle;
    @(posedge clk);
    #1;
  endtask : idle

  task automatic rw(input logic [3:0] s, input logic [15:0] exp);
    wregRdSel = s;
    @(posedge clk);
    #1 chk(wregRdData, exp);
  endtask : rw

  task automatic t_lanes;
    wr(AM_NEAR, 16'he800, 1'b0, 16'hbeef);
    rd(AM_ABS, 4'h0, 16'h0801, 1'b1, 16'h00be);
    rd(AM_ABS, 4'h0, 16'h0800, 1'b1, 16'h00ef);
    wr(AM_ABS, 16'h0801, 1'b1, 16'h0012);
    rd(AM_ABS, 4'h0, 16'h0800, 1'b0, 16'h12ef);
  endtask : t_lanes

  task automatic t_misal;
    wr(AM_ABS, 16'h0802, 1'b0, 16'h1111);
    idle();
    wr(AM_ABS, 16'h0803, 1'b0, 16'h2222);
    chk({15'h0000, addrErrTrap}, 16'h0001);
    rd(AM_ABS, 4'h0, 16'h0803, 1'b0, 16'h1111);
    chk({15'h0000, addrErrTrap}, 16'h0001);
  endtask : t_misal

  task automatic t_map;
    rd(AM_ABS, 4'h0, 16'h8004, 1'b0, 16'h04fb);
    rd(AM_ABS, 4'h0, 16'h7ffe, 1'b0, 16'h0000);
    rd(AM_ABS, 4'h0, 16'h0010, 1'b0, 16'h1244);
    rd(AM_ABS, 4'h0, 16'h0400, 1'b0, 16'h0000);
    rd(AM_NEAR, 4'h0, 16'he800, 1'b0, 16'h12ef);
    wr(AM_ABS, 16'h0011, 1'b1, 16'h0055);
    chk({14'h0000, sfrWrEn}, 16'h0002);
    chk(sfrWrAddr, 16'h0010);
    chk(sfrWrData, 16'h5555);
    idle();
    wr(AM_ABS, 16'h0013, 1'b0, 16'h3333);
    chk({14'h0000, sfrWrEn}, 16'h0000);
    chk({15'h0000, addrErrTrap}, 16'h0001);
  endtask : t_map

  task automatic t_wreg;
    wrw(4'h1, 1'b0, 16'h1234);
    idle();
    wrw(4'h1, 1'b1, 16'h00ab);
    rw(4'h1, 16'h12ab);
    ext(EXT_SIGN, 4'h1);
    rw(4'h1, 16'hffab);
    ext(EXT_ZERO, 4'h1);
    rw(4'h1, 16'h00ab);
  endtask : t_wreg

  task automatic t_postinc;
    wrw(4'h2, 1'b0, 16'h0800);
    rd(AM_INDIRECT, 4'h2, 16'h0000, 1'b0, 16'h12ef);
    rd(AM_POSTINC, 4'h2, 16'h0000, 1'b1, 16'h00ef);
    rw(4'h2, 16'h0801);
    rd(AM_POSTINC, 4'h2, 16'h0000, 1'b1, 16'h0012);
    rd(AM_POSTINC, 4'h2, 16'h0000, 1'b0, 16'h1111);
    rw(4'h2, 16'h0804);
    wrPtrSel = 4'h2;
    wr(AM_POSTINC, 16'h0000, 1'b1, 16'h0077);
    rw(4'h2, 16'h0805);
    rd(AM_ABS, 4'h0, 16'h0804, 1'b1, 16'h0077);
  endtask : t_postinc

  task automatic summarize;
    if (fails == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #20000;
    fails++;
    summarize();
  end

  initial
  begin
    {nrst, rdReq, rdIsByte, wrReq, wrIsByte, wregWrEn, wregWrByte} = 7'h00;
    {rdPtrSel, wrPtrSel, wregWrSel, extSel, wregRdSel} = 20'h00000;
    {rdLiteral, wrLiteral, wrData, wregWrData} = 64'h0;
    rdMode = AM_ABS;
    wrMode = AM_ABS;
    extOp = EXT_NONE;
    fails = 0;
    checksDone = 0;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk);
    #1;
    t_lanes();
    t_misal();
    t_map();
    t_wreg();
    t_postinc();
    summarize();
  end
endmodule : tb_data_space_access_unit
